// ---- verilog/lrs_pkg.sv ----
`default_nettype none
package lrs_pkg;
   // Sequencer phases, one-hot
   typedef enum logic [10:0] {
      LRS_IDLE   = 11'h001,  // Supply below start threshold or disabled
      LRS_RAMP1  = 11'h002,  // Initial fault check ramp
      LRS_RAMP2  = 11'h004,  // Reference and temperature check
      LRS_RAMP3  = 11'h008,  // Boost and logic soft-start
      LRS_RAMP4  = 11'h010,  // Waiting for fourth peak
      LRS_RAMP5  = 11'h020,  // Waiting for fifth peak
      LRS_RAMP6  = 11'h040,  // Positive gate rail ramp
      LRS_HOLD   = 11'h080,  // Sequence complete, cap held
      LRS_FRAMP  = 11'h100,  // Fault time-out ramp
      LRS_LATCH  = 11'h200,  // Latched off
      LRS_SPARE  = 11'h400   // Unused code
   } lrs_state_type;

   // Number of peaks in a complete power-up
   localparam logic [2:0] LRS_PEAKS_DONE = 3'h6;
   // Peak counter reset value
   localparam logic [2:0] LRS_PEAKS_RST  = 3'h0;
   // Fault time-out in microseconds, soft-start in microseconds (220 nF cap)
   localparam int LRS_FAULT_TO_US  = 50000;
   localparam int LRS_SOFTSTART_US = 2000;
   localparam int LRS_CLK_MHZ      = 50;
   // Cycle counts, least times rounded up
   localparam int LRS_FAULT_TO_CYC  = LRS_FAULT_TO_US * LRS_CLK_MHZ;
   localparam int LRS_SOFTSTART_CYC = LRS_SOFTSTART_US * LRS_CLK_MHZ;
endpackage : lrs_pkg
`default_nettype wire

// ---- verilog/lrs_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Any fault latches outputs off until enable/supply cycles
// - Six ramp peaks make a complete power-up
// - Above start threshold, charge cap slow on first ramp, then fast
// - First ramp checks faults; peak enables reference
// - Second ramp checks reference, temperature; peak closes switch
// - Fault opens the input protection switch
// - Standard variant: boost, logic soft-start at ramp three
// - Alternate: reference, logic on early; reference survives fault
// - Negative gate rail enabled at third peak
// - Fifth peak pulls delayed-boost output low
// - Sixth ramp enables positive rail, then checks all
// - After sequence, hold cap at fixed level
// - Fault charges cap to fault threshold, then disables
// - Fault time-out about 50 ms, scales with cap
// - Over-temperature shuts the device down
// - Protect gate not pulled low after sequence: fault
module lrs_sequencer
   import lrs_pkg::*;
#(
   parameter bit ALT_VARIANT   = 1'b0,             // 1 selects early logic rail variant
   parameter int FAULT_TO_CYC  = LRS_FAULT_TO_CYC  // Fault time-out length in clocks
)(
   // Clock, reset, enable
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic clk_en,
   // Analog comparator inputs (asynchronous)
   input  wire logic enable_in,        // Chip enable pin
   input  wire logic supply_ok,        // Input above start threshold
   input  wire logic cap_peak,         // Delay cap reached upper threshold
   input  wire logic cap_fault_thr,    // Delay cap reached fault threshold
   input  wire logic ref_ok,           // Reference in regulation
   input  wire logic over_temp,        // Die above thermal trip
   input  wire logic rail_fault,       // Any monitored rail undervoltage
   input  wire logic protect_gate_low, // Protect gate below its threshold
   // Delay cap control
   output logic      cap_charge,       // Current source on
   output logic      cap_slow,         // Slow ramp current selected
   output logic      cap_discharge,    // Discharge switch on
   output logic      cap_hold,         // Clamp at hold level
   // Rail and switch controls
   output logic      ref_en,
   output logic      protect_gate_out, // High keeps protection switch off
   output logic      boost_rail_en,
   output logic      logic_rail_en,
   output logic      gate_low_rail_en,
   output logic      gate_high_rail_en,
   output logic      delayed_boost_switch_n_out,
   output logic      delayed_boost_switch_n_oe,
   // Status
   output logic      fault_latched,
   output logic      seq_done
);

   logic          rst_s1_r, rst_s2_r;     // Reset release synchroniser
   logic [7:0]    sy1_r, sy2_r;           // Input synchronisers
   logic          peak_d_r;               // Previous peak level
   logic          peak_rise;              // Peak edge event
   logic          en_q, sup_q, pk_q, fthr_q, ref_q, ot_q, rf_q, pg_q;
   logic          fault_now;              // Fault in current check window
   lrs_state_type state_r, state_nxt;
   logic [2:0]    peaks_r;                // Peaks seen so far
   logic [31:0]   fto_r;                  // Fault time-out counter
   logic          fto_done;
   logic          lat_fault_r;            // Entered via a fault

   // Reset release through two flops
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end

   // Two-flop synchronisers on every analog input
   always_ff @(posedge clk or negedge rst_s2_r)
   begin
      if (!rst_s2_r)
      begin
         sy1_r <= 8'h00;
         sy2_r <= 8'h00;
      end
      else if (clk_en)
      begin
         sy1_r <= {enable_in, supply_ok, cap_peak, cap_fault_thr,
                   ref_ok, over_temp, rail_fault, protect_gate_low};
         sy2_r <= sy1_r;
      end
   end

   assign {en_q, sup_q, pk_q, fthr_q, ref_q, ot_q, rf_q, pg_q} = sy2_r;

   // Peak edge detect on the synchronised copy
   always_ff @(posedge clk or negedge rst_s2_r)
   begin
      if (!rst_s2_r)
         peak_d_r <= 1'b0;
      else if (clk_en)
         peak_d_r <= pk_q;
   end

   assign peak_rise = pk_q & ~peak_d_r;

   // Per-phase fault checks; temperature is watched in every active phase
   always_comb
   begin
      fault_now = ot_q;
      case (state_r)
         LRS_RAMP1: fault_now = ot_q | rf_q;
         LRS_RAMP2: fault_now = ot_q | ~ref_q;
         LRS_RAMP6: fault_now = ot_q | (peak_rise & (rf_q | ~pg_q));
         LRS_HOLD:  fault_now = ot_q | rf_q | ~pg_q;
         default:   fault_now = ot_q;
      endcase
   end

   // Fault time-out counter; the cap comparator also ends it
   always_ff @(posedge clk or negedge rst_s2_r)
   begin
      if (!rst_s2_r)
         fto_r <= 32'h0;
      else if (clk_en)
      begin
         if (state_r == LRS_FRAMP)
            fto_r <= fto_r + 32'h1;
         else
            fto_r <= 32'h0;
      end
   end

   assign fto_done = fthr_q | (fto_r >= 32'(FAULT_TO_CYC - 1));

   // Next phase
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         LRS_IDLE:
            if (en_q && sup_q)
               state_nxt = LRS_RAMP1;
         LRS_RAMP1, LRS_RAMP2, LRS_RAMP3, LRS_RAMP4, LRS_RAMP5, LRS_RAMP6:
            if (fault_now)
               state_nxt = LRS_FRAMP;
            else if (peak_rise)
            begin
               case (state_r)  // One phase per peak
                  LRS_RAMP1: state_nxt = LRS_RAMP2;
                  LRS_RAMP2: state_nxt = LRS_RAMP3;
                  LRS_RAMP3: state_nxt = LRS_RAMP4;
                  LRS_RAMP4: state_nxt = LRS_RAMP5;
                  LRS_RAMP5: state_nxt = LRS_RAMP6;
                  // Sixth peak completes only if the count agrees; a lost peak is a fault
                  default:   state_nxt = (peaks_r == LRS_PEAKS_DONE - 3'h1) ? LRS_HOLD : LRS_FRAMP;
               endcase
            end
         LRS_HOLD:
            if (fault_now)
               state_nxt = LRS_FRAMP;
         LRS_FRAMP:
            if (fto_done)
               state_nxt = LRS_LATCH;
         LRS_LATCH:
            state_nxt = LRS_LATCH;
         default:
            state_nxt = LRS_IDLE;
      endcase
      // Enable or supply loss always returns to idle, clearing the latch
      if (!en_q || !sup_q)
         state_nxt = LRS_IDLE;
   end

   // State register
   always_ff @(posedge clk or negedge rst_s2_r)
   begin
      if (!rst_s2_r)
         state_r <= LRS_IDLE;
      else if (clk_en)
         state_r <= state_nxt;
   end

   // Peak count, checked at the sixth peak; also marks fault history
   always_ff @(posedge clk or negedge rst_s2_r)
   begin
      if (!rst_s2_r)
      begin
         peaks_r     <= LRS_PEAKS_RST;
         lat_fault_r <= 1'b0;
      end
      else if (clk_en)
      begin
         if (state_nxt == LRS_IDLE)
            peaks_r <= LRS_PEAKS_RST;
         else if (peak_rise && peaks_r != LRS_PEAKS_DONE)
            peaks_r <= peaks_r + 3'h1;
         lat_fault_r <= (state_nxt == LRS_FRAMP) || (state_nxt == LRS_LATCH);
      end
   end

   // Registered outputs from the next state, so they track the phase exactly
   always_ff @(posedge clk or negedge rst_s2_r)
   begin
      if (!rst_s2_r)
      begin
         cap_charge                 <= 1'b0;
         cap_slow                   <= 1'b0;
         cap_discharge              <= 1'b1;
         cap_hold                   <= 1'b0;
         ref_en                     <= 1'b0;
         protect_gate_out           <= 1'b1;
         boost_rail_en              <= 1'b0;
         logic_rail_en              <= 1'b0;
         gate_low_rail_en           <= 1'b0;
         gate_high_rail_en          <= 1'b0;
         delayed_boost_switch_n_out <= 1'b0;
         delayed_boost_switch_n_oe  <= 1'b0;
         fault_latched              <= 1'b0;
         seq_done                   <= 1'b0;
      end
      else if (clk_en)
      begin
         // Cap: ramp in phases, held after, charged again on fault
         cap_charge    <= state_nxt[6:1] != 6'h0 || state_nxt == LRS_FRAMP;
         cap_slow      <= state_nxt == LRS_RAMP1;
         cap_discharge <= peak_rise || state_nxt == LRS_IDLE || state_nxt == LRS_LATCH;
         cap_hold      <= state_nxt == LRS_HOLD;
         // Reference from second ramp on; alternate variant keeps it up
         ref_en <= (ALT_VARIANT && sup_q) ||
                   (state_nxt[7:2] != 6'h0);
         // Protection switch closed from third ramp; fault opens it
         protect_gate_out  <= !(state_nxt[7:3] != 5'h0);
         boost_rail_en     <= state_nxt[7:3] != 5'h0;
         logic_rail_en     <= ALT_VARIANT ? (sup_q && !lat_fault_r && state_nxt != LRS_FRAMP
                                             && state_nxt != LRS_LATCH)
                                          : (state_nxt[7:3] != 5'h0);
         // Negative rail from the start of the fourth ramp
         gate_low_rail_en  <= state_nxt[7:4] != 4'h0;
         gate_high_rail_en <= state_nxt[7:6] != 2'h0;
         // Open drain: drive low from fifth peak on
         delayed_boost_switch_n_out <= 1'b0;
         delayed_boost_switch_n_oe  <= state_nxt[7:6] != 2'h0;
         fault_latched <= state_nxt == LRS_FRAMP || state_nxt == LRS_LATCH;
         seq_done      <= state_nxt == LRS_HOLD;
      end
   end

endmodule : lrs_sequencer
`default_nettype wire

// ---- tb/lrs_sequencer_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module lrs_sequencer_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pins watched
   input wire logic enable_in,
   input wire logic supply_ok,
   input wire logic over_temp,
   input wire logic protect_gate_low,
   // Cap control watched
   input wire logic cap_charge,
   input wire logic cap_slow,
   input wire logic cap_discharge,
   input wire logic cap_hold,
   // Rails watched
   input wire logic protect_gate_out,
   input wire logic ref_en,
   input wire logic boost_rail_en,
   input wire logic gate_low_rail_en,
   input wire logic gate_high_rail_en,
   input wire logic delayed_boost_switch_n_out,
   input wire logic delayed_boost_switch_n_oe,
   // Status watched
   input wire logic fault_latched,
   input wire logic seq_done
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_FLT_OFF: assert property (
      fault_latched |-> protect_gate_out && !boost_rail_en && !gate_high_rail_en && !delayed_boost_switch_n_oe)
      else $error("rail on while latched");
   AST_DONE: assert property (seq_done |-> cap_hold && gate_high_rail_en && !protect_gate_out)
      else $error("hold without full rails");
   AST_HIGH: assert property (gate_high_rail_en |-> delayed_boost_switch_n_oe && gate_low_rail_en)
      else $error("positive rail early");
   AST_DELAYED_BOOST_SWITCH_N: assert property (
      delayed_boost_switch_n_oe |-> gate_low_rail_en && delayed_boost_switch_n_out == 1'b0)
      else $error("delayed switch early");
   AST_LOW: assert property (gate_low_rail_en |-> boost_rail_en && !protect_gate_out)
      else $error("negative rail early");
   AST_BOOST: assert property (boost_rail_en |-> ref_en)
      else $error("boost before reference");
   AST_HOT: assert property ((over_temp && enable_in && supply_ok) [*3] |-> ##[0:3] fault_latched)
      else $error("no shutdown when hot");
   AST_EN: assert property ((!enable_in) [*4] |-> ##[0:2] !fault_latched && !seq_done)
      else $error("no idle after enable low");
   AST_SINK: assert property ((seq_done && !protect_gate_low) [*3] |-> ##[0:3] fault_latched)
      else $error("stuck gate not flagged");
   AST_SLOW: assert property (cap_slow |-> cap_charge && !boost_rail_en)
      else $error("slow ramp outside first ramp");
   AST_DISCH: assert property ($rose(boost_rail_en) |-> cap_discharge)
      else $error("rail step without cap discharge");
   // Main scenarios reached
   cover property ($rose(seq_done));
   cover property ($rose(fault_latched));
   cover property ($rose(gate_high_rail_en));
endmodule : lrs_sequencer_asserts
`default_nettype wire

// ---- tb/lrs_cap_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module lrs_cap_model #(parameter int RAMP = 12) (
   // Controls from the sequencer
   input  wire logic clk, charge, discharge, hold, flt, gate_out, sink_bad,
   // Comparator levels back
   output logic      peak, fthr, gate_low
);
   int n, f, g; // Ramp, fault ramp and sink ages
   // Discharge, hold, fault or charge off empties the cap; without the discharge pulse the peak sticks and the bench times out
   always @(posedge clk)
   begin
      n <= (charge && !hold && !flt && !discharge) ? n + 1 : 0;
      f <= flt ? f + 1 : 0;
      g <= gate_out ? 0 : g + 1;
   end
   assign peak     = n >= RAMP;
   assign fthr     = f >= 2 * RAMP;
   assign gate_low = !sink_bad && g >= 3;
endmodule : lrs_cap_model
`default_nettype wire

// ---- tb/test_lcd_rail_startup_fault_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_lcd_rail_startup_fault_sequencer;
   import lrs_pkg::*;
   // Pins and bench state
   logic clk, rst_n, enable_in, supply_ok, ref_ok, over_temp, rail_fault, sink_bad;
   logic clk_en = 1'b1;
   logic cap_peak, cap_fault_thr, protect_gate_low, cap_charge, cap_slow, cap_discharge, cap_hold;
   logic ref_en, protect_gate_out, boost_rail_en, logic_rail_en, gate_low_rail_en, gate_high_rail_en;
   logic delayed_boost_switch_n_out, delayed_boost_switch_n_oe, fault_latched, seq_done;
   int   errors, checked, seed, k, p;
   logic alt_ref, alt_logic;  // Alternate-variant copy on the same pins
   wire  [8:0] vec = {fault_latched, ref_en, protect_gate_out, boost_rail_en, logic_rail_en,
                      gate_low_rail_en, delayed_boost_switch_n_oe, gate_high_rail_en, seq_done};
   lrs_sequencer #(.FAULT_TO_CYC(40)) DUT (.clk, .rst_n, .clk_en, .enable_in, .supply_ok, .cap_peak,
      .cap_fault_thr, .ref_ok, .over_temp, .rail_fault, .protect_gate_low, .cap_charge, .cap_slow,
      .cap_discharge, .cap_hold, .ref_en, .protect_gate_out, .boost_rail_en, .logic_rail_en,
      .gate_low_rail_en, .gate_high_rail_en, .delayed_boost_switch_n_out, .delayed_boost_switch_n_oe,
      .fault_latched, .seq_done);
   lrs_sequencer #(.ALT_VARIANT(1'b1), .FAULT_TO_CYC(40)) DUT_ALT (.clk, .rst_n, .clk_en, .enable_in,
      .supply_ok, .cap_peak, .cap_fault_thr, .ref_ok, .over_temp, .rail_fault, .protect_gate_low,
      .cap_charge(), .cap_slow(), .cap_discharge(), .cap_hold(), .ref_en(alt_ref), .protect_gate_out(),
      .boost_rail_en(), .logic_rail_en(alt_logic), .gate_low_rail_en(), .gate_high_rail_en(),
      .delayed_boost_switch_n_out(), .delayed_boost_switch_n_oe(), .fault_latched(), .seq_done());
   lrs_cap_model #(.RAMP(16)) partner (.clk, .charge(cap_charge), .hold(cap_hold), .flt(fault_latched),
      .discharge(cap_discharge), .gate_out(protect_gate_out), .sink_bad, .peak(cap_peak), .fthr(cap_fault_thr),
      .gate_low(protect_gate_low));
   // Expected pins after k peaks; the fourth peak changes none
   function automatic logic [8:0] model(input int k);
      return {1'b0, k >= 1, k < 2, k >= 2, k >= 2, k >= 3, k >= 5, k >= 5, k >= 6};
   endfunction : model
   // Verdict and end of run
   task automatic summarize;
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize
   // Compare one result
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Bounded wait for a level on the fault flag or the cap peak
   task automatic await(input bit on_fault, input logic lvl);
      int i;
      for (i = 0; i < 400 && (on_fault ? fault_latched : cap_peak) !== lvl; i++)
         @(negedge clk);
      if (i == 400)
      begin
         errors++;
         summarize();
      end
   endtask : await
   // Free-running clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Power-ups with every fault kind, then an early enable drop
   initial
   begin
      seed = 32'h194a;
      {rst_n, enable_in, supply_ok, ref_ok, over_temp, rail_fault, sink_bad} = 7'h08;
      repeat (10) @(negedge clk);
      chk(vec, model(0));
      rst_n = 1'b1;
      for (k = 0; k < 5; k++)
      begin
         {enable_in, supply_ok} = 2'h3;
         // Clock enable low holds the block idle even with supply up
         clk_en = 1'b0;
         repeat (8) @(negedge clk);
         chk({6'h0, cap_charge, cap_slow, cap_hold}, 9'h000);
         clk_en = 1'b1;
         repeat (6) @(negedge clk);
         chk({6'h0, cap_charge, cap_slow, cap_hold}, 9'h006);
         for (p = 1; p <= (k > 2 ? k - 2 : 6); p++)
         begin
            await(1'b0, 1'b1);
            repeat (8) @(negedge clk);
            chk(vec, model(p));
            chk({7'h0, alt_ref, alt_logic}, 9'h003);
            await(1'b0, 1'b0);
         end
         repeat ($unsigned($random(seed)) % 8) @(negedge clk);
         case (k)
            0: rail_fault = 1'b1;
            1: over_temp = 1'b1;
            2: sink_bad = 1'b1;
            3: ref_ok = 1'b0;
            default: enable_in = 1'b0;
         endcase
         if (k < 4)
         begin
            await(1'b1, 1'b1);
            {rail_fault, over_temp, sink_bad, ref_ok} = 4'h1;
            repeat (60) @(negedge clk);
            chk(vec, 9'h140);
            chk({5'h0, cap_charge, cap_discharge, alt_ref, alt_logic}, 9'h006);
            if (k == 1)
               supply_ok = 1'b0;
            else
               enable_in = 1'b0;
         end
         repeat (6) @(negedge clk);
         chk(vec, model(0));
         chk({7'h0, alt_ref, alt_logic}, {7'h0, supply_ok, supply_ok});
      end
      summarize();
   end
endmodule : test_lcd_rail_startup_fault_sequencer
bind lrs_sequencer lrs_sequencer_asserts chk_i (.clk(clk), .rst_n(rst_n), .enable_in(enable_in),
   .supply_ok(supply_ok), .over_temp(over_temp), .protect_gate_low(protect_gate_low), .cap_charge(cap_charge),
   .cap_slow(cap_slow), .cap_discharge(cap_discharge), .cap_hold(cap_hold), .protect_gate_out(protect_gate_out),
   .ref_en(ref_en), .boost_rail_en(boost_rail_en), .gate_low_rail_en(gate_low_rail_en),
   .gate_high_rail_en(gate_high_rail_en), .delayed_boost_switch_n_out(delayed_boost_switch_n_out),
   .delayed_boost_switch_n_oe(delayed_boost_switch_n_oe), .fault_latched(fault_latched), .seq_done(seq_done));
`default_nettype wire
